// >>> dhsa_map.vh
`ifndef DHSA_MAP_VH
`define DHSA_MAP_VH
// ************************************************************
// operation codes
// ************************************************************
`define DHSA_OP_ADD 8'h46
`define DHSA_OP_SUB 8'h47
`define DHSA_OP_ABS 8'h48
// multiply code is not known; a parameter default is used instead
`define DHSA_OP_MUL_DEFAULT 8'h00
// ************************************************************
// timing and layout
// ************************************************************
`define DHSA_LATENCY 2
`define DHSA_SLOT_A 3'h1
`define DHSA_SLOT_B 3'h3
`define DHSA_HI_MSB 31
`define DHSA_HI_LSB 16
`define DHSA_LO_MSB 15
`define DHSA_LO_LSB 0
`define DHSA_SAT_MAX 16'h7FFF
`define DHSA_SAT_MIN 16'h8000
`define DHSA_SEL_ADD 2'h0
`define DHSA_SEL_SUB 2'h1
`define DHSA_SEL_MUL 2'h2
`define DHSA_SEL_ABS 2'h3
`endif

// >>> dhsa_lane.v
`include "dhsa_map.vh"
`default_nettype none
// ************************************************************
// one saturating halfword lane, purely combinational
// ************************************************************
module dhsa_lane (
  // operands
  input wire [15:0] a_i,
  input wire [15:0] b_i,
  input wire [1:0] sel_i,
  // result
  output reg [15:0] res_o
);
  wire signed [31:0] a_ext;
  wire signed [31:0] b_ext;
  reg signed [31:0] tmp;
  assign a_ext = {{16{a_i[15]}}, a_i};
  assign b_ext = {{16{b_i[15]}}, b_i};
  always @* begin
    case (sel_i)
      `DHSA_SEL_ADD: tmp = a_ext + b_ext;
      `DHSA_SEL_SUB: tmp = a_ext - b_ext;
      `DHSA_SEL_MUL: tmp = a_ext * b_ext;
      // abs works on the second operand; first is the zero constant
      `DHSA_SEL_ABS: tmp = b_ext[31] ? (32'sh0 - b_ext) : b_ext;
      default: tmp = 32'sh0;
    endcase
    // 32-bit intermediate cannot wrap for 16x16 products
    if (tmp > $signed({16'h0000, `DHSA_SAT_MAX})) begin
      res_o = `DHSA_SAT_MAX;
    end else if (tmp < $signed({16'hFFFF, `DHSA_SAT_MIN})) begin
      res_o = `DHSA_SAT_MIN;
    end else begin
      res_o = tmp[15:0];
    end
  end
endmodule // dhsa_lane
`default_nettype wire

// >>> dhsa_alu.v
`include "dhsa_map.vh"
`default_nettype none
module dhsa_alu #(
  parameter [7:0] OP_MUL = `DHSA_OP_MUL_DEFAULT
) (
  // clock and reset
  input wire CLOCK_I,
  input wire RST_N_I,
  // issue
  input wire ISSUE_VALID_I,
  input wire [2:0] ISSUE_SLOT_I,
  input wire [7:0] OPCODE_I,
  input wire [4:0] DEST_IDX_I,
  input wire GUARD_PRESENT_I,
  input wire [31:0] GUARD_I,
  input wire [31:0] FIRST_SOURCE_OPERAND_I,
  input wire [31:0] SECOND_SOURCE_OPERAND_I,
  // write-back
  output reg WB_EN_O,
  output reg [4:0] WB_IDX_O,
  output reg [31:0] WB_DATA_O
);
  // ************************************************************
  // local constants
  // ************************************************************
  localparam [7:0] OP_ADD = `DHSA_OP_ADD;
  localparam [7:0] OP_SUB = `DHSA_OP_SUB;
  localparam [7:0] OP_ABS = `DHSA_OP_ABS;

  localparam [2:0] SLOT_A = `DHSA_SLOT_A;
  localparam [2:0] SLOT_B = `DHSA_SLOT_B;

  localparam [1:0] SEL_ADD = `DHSA_SEL_ADD;
  localparam [1:0] SEL_SUB = `DHSA_SEL_SUB;
  localparam [1:0] SEL_MUL = `DHSA_SEL_MUL;
  localparam [1:0] SEL_ABS = `DHSA_SEL_ABS;

  localparam [4:0] IDX_RESET = 5'h00;
  localparam [31:0] DATA_RESET = 32'h00000000;
  localparam [15:0] HALF_RESET = 16'h0000;

  // ************************************************************
  // issue fields
  // ************************************************************
  wire issue_valid;
  wire [2:0] issue_slot;
  wire [7:0] opcode;
  wire [4:0] dest_idx;
  wire guard_present;
  wire guard_bit;

  wire [15:0] first_hi;
  wire [15:0] first_lo;
  wire [15:0] second_hi;
  wire [15:0] second_lo;

  assign issue_valid = ISSUE_VALID_I;
  assign issue_slot = ISSUE_SLOT_I;
  assign opcode = OPCODE_I;
  assign dest_idx = DEST_IDX_I;
  assign guard_present = GUARD_PRESENT_I;
  // only bit 0 of the guard matters; the upper bits are ignored
  assign guard_bit = GUARD_I[0];

  assign first_hi = FIRST_SOURCE_OPERAND_I[`DHSA_HI_MSB:`DHSA_HI_LSB];
  assign first_lo = FIRST_SOURCE_OPERAND_I[`DHSA_LO_MSB:`DHSA_LO_LSB];
  assign second_hi = SECOND_SOURCE_OPERAND_I[`DHSA_HI_MSB:`DHSA_HI_LSB];
  assign second_lo = SECOND_SOURCE_OPERAND_I[`DHSA_LO_MSB:`DHSA_LO_LSB];

  // ************************************************************
  // decode
  // ************************************************************
  wire is_add;
  wire is_sub;
  wire is_abs;
  wire is_mul;
  wire known;

  wire slot_a;
  wire slot_b;
  wire slot_ok;

  wire guard_ok;
  wire accept;

  reg [1:0] sel;

  assign is_add = (opcode == OP_ADD);
  assign is_sub = (opcode == OP_SUB);
  assign is_abs = (opcode == OP_ABS);
  assign is_mul = (opcode == OP_MUL);
  assign known = is_add || is_sub || is_abs || is_mul;

  // only two of the issue slots feed this unit
  assign slot_a = (issue_slot == SLOT_A);
  assign slot_b = (issue_slot == SLOT_B);
  assign slot_ok = slot_a || slot_b;

  assign guard_ok = !guard_present || guard_bit;

  // bad slot or unknown code is dropped silently, as is a false guard
  assign accept = issue_valid && known && slot_ok && guard_ok;

  // fixed codes win if the multiply code is set to collide with one
  always @* begin
    sel = SEL_MUL;
    if (is_add) begin
      sel = SEL_ADD;
    end else if (is_sub) begin
      sel = SEL_SUB;
    end else if (is_abs) begin
      sel = SEL_ABS;
    end
  end

  // ************************************************************
  // lanes: separate instances, so no carry crosses bit 16
  // ************************************************************
  wire [15:0] hi_res;
  wire [15:0] lo_res;

  // abs ignores the first operand; the scheduler passes zero there
  dhsa_lane u_hi (
    .a_i(first_hi),
    .b_i(second_hi),
    .sel_i(sel),
    .res_o(hi_res)
  );

  dhsa_lane u_lo (
    .a_i(first_lo),
    .b_i(second_lo),
    .sel_i(sel),
    .res_o(lo_res)
  );

  // ************************************************************
  // stage one: lane results captured at the issue edge
  // ************************************************************
  reg s1_en_d;
  reg s1_en_q;

  reg [4:0] s1_idx_d;
  reg [4:0] s1_idx_q;
  reg [15:0] s1_hi_d;
  reg [15:0] s1_hi_q;
  reg [15:0] s1_lo_d;
  reg [15:0] s1_lo_q;

  // a refused op must not disturb the captured values
  always @* begin
    s1_en_d = accept;
    s1_idx_d = s1_idx_q;
    s1_hi_d = s1_hi_q;
    s1_lo_d = s1_lo_q;
    if (accept) begin
      s1_idx_d = dest_idx;
      s1_hi_d = hi_res;
      s1_lo_d = lo_res;
    end
  end

  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      s1_en_q <= 1'b0;
      s1_idx_q <= IDX_RESET;
      s1_hi_q <= HALF_RESET;
      s1_lo_q <= HALF_RESET;
    end else begin
      s1_en_q <= s1_en_d;
      s1_idx_q <= s1_idx_d;
      s1_hi_q <= s1_hi_d;
      s1_lo_q <= s1_lo_d;
    end
  end

  // ************************************************************
  // stage two: write-back, two edges after issue
  // ************************************************************
  reg wb_en_d;

  reg [4:0] wb_idx_d;
  reg [31:0] wb_data_d;

  // index and data hold between pulses; only the enable is a strobe
  always @* begin
    wb_en_d = s1_en_q;
    wb_idx_d = WB_IDX_O;
    wb_data_d = WB_DATA_O;
    if (s1_en_q) begin
      wb_idx_d = s1_idx_q;
      wb_data_d = {s1_hi_q, s1_lo_q};
    end
  end

  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      WB_EN_O <= 1'b0;
      WB_IDX_O <= IDX_RESET;
      WB_DATA_O <= DATA_RESET;
    end else begin
      WB_EN_O <= wb_en_d;
      WB_IDX_O <= wb_idx_d;
      WB_DATA_O <= wb_data_d;
    end
  end

endmodule // dhsa_alu
`default_nettype wire

// >>> dhsa_rf_model.sv
`default_nettype none
module dhsa_rf_model (
  input wire logic clk_i, wb_en_i,
  input wire logic [4:0] wb_idx_i,
  input wire logic [31:0] wb_data_i
);
  logic [31:0] regs_q [32];
  // a refused op never reaches here, so its register keeps its old value
  always @(posedge clk_i) if (wb_en_i) regs_q[wb_idx_i] <= wb_data_i;
endmodule // dhsa_rf_model
`default_nettype wire

// >>> dhsa_alu_asserts.sv
`default_nettype none
module dhsa_alu_asserts #(parameter [7:0] OP_MUL = 8'h00) (
  input wire logic CLOCK_I, RST_N_I, ISSUE_VALID_I, GUARD_PRESENT_I, WB_EN_O,
  input wire logic [2:0] ISSUE_SLOT_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic [4:0] DEST_IDX_I, WB_IDX_O,
  input wire logic [31:0] GUARD_I, FIRST_SOURCE_OPERAND_I, SECOND_SOURCE_OPERAND_I, WB_DATA_O
);
  wire logic [31:0] s = SECOND_SOURCE_OPERAND_I;
  wire logic [7:0] op = OPCODE_I;
  wire logic take = ISSUE_VALID_I && (ISSUE_SLOT_I == 3'h1 || ISSUE_SLOT_I == 3'h3) &&
    op inside {8'h46, 8'h47, 8'h48, OP_MUL} && (!GUARD_PRESENT_I || GUARD_I[0]);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  property p_lat; take |-> ##2 WB_EN_O; endproperty
  a_lat: assert property (p_lat) else $error("no write");
  property p_ref; !take |-> ##2 !WB_EN_O; endproperty
  a_ref: assert property (p_ref) else $error("bad write");
  property p_idx; take |-> ##2 WB_IDX_O == $past(DEST_IDX_I, 2); endproperty
  a_idx: assert property (p_idx) else $error("index");
  property p_hold; !WB_EN_O |-> $stable(WB_DATA_O); endproperty
  a_hold: assert property (p_hold) else $error("moved");
  property p_abs; take && op == 8'h48 |-> ##2 !WB_DATA_O[31] && !WB_DATA_O[15]; endproperty
  a_abs: assert property (p_abs) else $error("abs");
  property p_add; take && op == 8'h46 && s == 32'h0 |-> ##2
    WB_DATA_O == $past(FIRST_SOURCE_OPERAND_I, 2); endproperty
  a_add: assert property (p_add) else $error("add");
  property p_sub; take && op == 8'h47 && s == FIRST_SOURCE_OPERAND_I |-> ##2
    WB_DATA_O == 32'h0; endproperty
  a_sub: assert property (p_sub) else $error("sub");
  property p_mul; take && op == OP_MUL && s == 32'h0 |-> ##2 WB_DATA_O == 32'h0; endproperty
  a_mul: assert property (p_mul) else $error("mul");
  c_add: cover property (take && op == 8'h46);
  c_abs: cover property (take && op == 8'h48);
  c_off: cover property (ISSUE_VALID_I && !take);
endmodule // dhsa_alu_asserts
bind dhsa_alu dhsa_alu_asserts #(.OP_MUL(OP_MUL)) dhsa_alu_asserts_inst (.*);
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_I = '0, RST_N_I = '0, ISSUE_VALID_I = '0, GUARD_PRESENT_I = '0, WB_EN_O;
  logic [2:0] ISSUE_SLOT_I = 3'h1;
  logic [7:0] OPCODE_I = 8'h00;
  logic [4:0] DEST_IDX_I = 5'h00, WB_IDX_O;
  logic [31:0] GUARD_I = '0, FIRST_SOURCE_OPERAND_I = '0, SECOND_SOURCE_OPERAND_I = '0, WB_DATA_O;
  int failures = 0, check_count = 0, cyc = 0;
  dhsa_alu dhsa_alu_inst (.*);
  dhsa_rf_model dhsa_rf_model_inst (.clk_i(CLOCK_I), .wb_en_i(WB_EN_O), .wb_idx_i(WB_IDX_O),
    .wb_data_i(WB_DATA_O));
  initial forever #2.5 CLOCK_I = ~CLOCK_I;
  always @(posedge CLOCK_I) cyc <= cyc + 1;
  always @(posedge CLOCK_I) if (cyc == 400) report_and_stop;
  logic [4:0] last_idx = 5'h00;
  // a refused op must leave the last write-back standing, so x is that value
  task automatic op(input logic [7:0] o, input logic [31:0] a, b, x, input logic e);
    @(posedge CLOCK_I) #1;
    {ISSUE_VALID_I, OPCODE_I, DEST_IDX_I} = {1'b1, o, 5'(check_count)};
    {FIRST_SOURCE_OPERAND_I, SECOND_SOURCE_OPERAND_I} = {a, b};
    // taken at the next edge; the enable then stands for the cycle after the following one
    @(posedge CLOCK_I) #1 ISSUE_VALID_I = 1'b0;
    @(posedge CLOCK_I) #1 check_count++;
    if ({WB_EN_O, WB_IDX_O, WB_DATA_O} !== {e, (e ? DEST_IDX_I : last_idx), x}) begin
      failures++;
      $display("wrong value at %0t: %h %h", $time, {WB_EN_O, WB_IDX_O, WB_DATA_O},
        {e, (e ? DEST_IDX_I : last_idx), x});
    end
    if (e) last_idx = DEST_IDX_I;
    // the register file takes the write at the edge that ends the pulse
    @(posedge CLOCK_I) #1 check_count++;
    if (dhsa_rf_model_inst.regs_q[last_idx] !== x) begin
      failures++;
      $display("wrong value at %0t: %h %h", $time, dhsa_rf_model_inst.regs_q[last_idx], x);
    end
  endtask
  task automatic t_compute;
    op(8'h46, 32'h80000001, 32'hFFFF7FFF, 32'h80007FFF, 1);
    op(8'h46, 32'h12345678, 32'h0, 32'h12345678, 1);
    op(8'h47, 32'h00018001, 32'h80010002, 32'h7FFF8000, 1);
    op(8'h00, 32'h80000002, 32'h00024000, 32'h80007FFF, 1);
    op(8'h00, 32'h7FFF8000, 32'h0, 32'h0, 1);
    op(8'h48, 32'h0, 32'h80008001, 32'h7FFF7FFF, 1);
    op(8'h48, 32'h0, 32'hFFFF0032, 32'h00010032, 1);
    $display("compute done");
  endtask
  task automatic t_refuse;
    {GUARD_PRESENT_I, GUARD_I} = {1'b1, 32'hFFFFFFFE};
    op(8'h46, 32'h1, 32'h1, 32'h00010032, 0);
    {GUARD_I, ISSUE_SLOT_I} = {32'h1, 3'h2};
    op(8'h47, 32'h80008000, 32'h80008000, 32'h00010032, 0);
    ISSUE_SLOT_I = 3'h3;
    op(8'h47, 32'h80008000, 32'h80008000, 32'h0, 1);
    $display("refuse done");
  endtask
  initial begin
    repeat (10) @(posedge CLOCK_I);
    #1 RST_N_I = 1'b1;
    t_compute;
    t_refuse;
    report_and_stop;
  end
  task automatic report_and_stop;
    failures += int'(cyc >= 400);
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule // tb
`default_nettype wire
